// *** pkg/isa_sig_pkg.sv ***
// Package: constants and carrier structs for the ISA slot signal control block
`default_nettype none
package isa_sig_pkg;
	// ============================================================
	// Timing
	localparam int unsigned CLK_HZ             = 40000000;
	localparam int unsigned REFRESH_PERIOD_NS  = 15600;
	localparam int unsigned REFRESH_CYC        = (REFRESH_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int unsigned REFRESH_LEN_CYC    = 4;
	localparam int unsigned RESET_SYNC_STAGES  = 2;
	localparam logic [3:0]  DIV_RESET          = 4'h2;
	// ============================================================
	// Field positions and encodings
	localparam int unsigned CLKDIV_W           = 5;
	localparam logic [4:0]  CLKDIV_DIV2        = 5'h00;
	localparam logic [4:0]  CLKDIV_DIV3        = 5'h01;
	localparam logic [4:0]  CLKDIV_DIV4        = 5'h02;
	localparam logic [4:0]  CLKDIV_DIV6        = 5'h03;
	localparam logic [4:0]  CLKDIV_DIV8        = 5'h04;
	localparam logic [23:0] MEG_LIMIT          = 24'h100000;
	localparam logic [13:0] REFRESH_CNT_INIT   = 14'h0000;

	typedef enum logic [1:0]
	{
		REF_IDLE = 2'b00,
		REF_RUN  = 2'b01,
		REF_END  = 2'b10
	} ref_state_e;

	// Request from the internal bus sequencer for one ISA cycle
	typedef struct packed
	{
		logic        cyc_valid;
		logic        is_mem;
		logic        is_write;
		logic [23:0] addr;
	} bus_req_s;

	// DMA view of the low address lines
	typedef struct packed
	{
		logic       dma_active;
		logic       dma_16bit;
		logic [1:0] dma_addr;
		logic       tc_any;
	} dma_view_s;

	// Slot pin group: output value and output enable
	typedef struct packed
	{
		logic [1:0] sa_o;
		logic       sa_oe;
		logic       sbhe_n_o;
		logic       sbhe_oe;
	} addr_pins_s;
endpackage
`default_nettype wire

// *** rtl/isa_bus_signal_control.sv ***
// Module: ISA slot-side refresh, reset, low address, strobe and clock logic
`default_nettype none
module isa_bus_signal_control
	import isa_sig_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                clk_en,
	// Reset sources
	input  wire logic                supply_ok_in,
	input  wire logic                processor_reset_out,
	input  wire logic                numeric_error_ignore,
	// Clock selection
	input  wire logic                bus_osc_clk,
	input  wire logic                cpu_double_clk,
	input  wire logic                osc_select,
	input  wire logic [CLKDIV_W-1:0] clock_divide_control,
	// CPU and DMA side
	input  wire logic [3:0]          cpu_byte_enables_n,
	input  wire logic                hold_acknowledge,
	input  wire logic                master_n,
	input  wire bus_req_s            bus_req,
	input  wire dma_view_s           dma_view,
	input  wire logic [3:0]          default_wait_len,
	// Slot pins
	input  wire logic                refresh_n_i,
	output logic                     refresh_n_o,
	output logic                     refresh_n_oe,
	input  wire logic                ws_term_n,
	output logic                     slot_reset,
	output addr_pins_s               addr_pins,
	output logic                     sa1_late_timing,
	output logic                     sys_clk,
	output logic                     addr_latch_en,
	output logic                     io_rd_n,
	output logic                     io_wr_n,
	output logic                     smem_rd_n,
	output logic                     smem_wr_n,
	output logic                     term_count,
	output logic                     cycle_done,
	output logic                     refresh_active
);
	// ============================================================
	// State
	typedef struct packed
	{
		logic [RESET_SYNC_STAGES-1:0] rst_sync;
		logic                         slot_reset;
		logic                         strap_taken;
		logic                         sa1_late;
		logic [13:0]                  ref_cnt;
		ref_state_e                   ref_state;
		logic [2:0]                   ref_len;
		logic                         ref_oe;
		logic                         ref_act;
		logic                         src_prev;
		logic [3:0]                   div_cnt;
		logic                         sys_clk;
		logic                         sys_rise;
		logic [3:0]                   wait_cnt;
		logic                         cyc_busy;
		logic                         cyc_mem;
		logic                         cyc_wr;
		logic                         cyc_low;
		logic                         ale;
		logic                         io_rd_n;
		logic                         io_wr_n;
		logic                         smem_rd_n;
		logic                         smem_wr_n;
		logic                         done;
		logic                         tc;
		addr_pins_s                   pins;
	} state_s;

	state_s st_q;
	state_s st_d;

	// Reset image: strobes and byte-high enable idle high, pins released
	localparam state_s ST_RST = '{
		slot_reset: 1'b1, io_rd_n: 1'b1, io_wr_n: 1'b1, smem_rd_n: 1'b1, smem_wr_n: 1'b1,
		ref_state: REF_IDLE,
		pins: '{sa_o: 2'h0, sa_oe: 1'b0, sbhe_n_o: 1'b1, sbhe_oe: 1'b0},
		default: '0};

	// ============================================================
	// Helpers
	// Source rises per bus clock period; unused codes fall back to the fastest ratio
	function automatic logic [3:0] div_ratio(input logic [4:0] sel);
		unique case (sel)
			CLKDIV_DIV3: div_ratio = 4'h3;
			CLKDIV_DIV4: div_ratio = 4'h4;
			CLKDIV_DIV6: div_ratio = 4'h6;
			CLKDIV_DIV8: div_ratio = 4'h8;
			default:     div_ratio = 4'h2;
		endcase
	endfunction

	function automatic logic [1:0] be_decode(input logic [3:0] be_n);
		if (!be_n[0])
			be_decode = 2'h0;
		else if (!be_n[1])
			be_decode = 2'h1;
		else if (!be_n[2])
			be_decode = 2'h2;
		else
			be_decode = 2'h3;
	endfunction

	// ============================================================
	// Next state
	always_comb
	begin
		logic       src;
		logic       ext_master;
		logic       ref_go;
		logic       in_ref;
		logic [1:0] sa;
		logic [3:0] ratio;
		logic [3:0] div_nx;
		st_d       = st_q;
		src        = osc_select ? bus_osc_clk : cpu_double_clk;
		ext_master = hold_acknowledge && !master_n;
		ref_go     = 1'b0;
		in_ref     = 1'b0;
		sa         = 2'h0;
		ratio      = div_ratio(clock_divide_control);
		div_nx     = st_q.div_cnt;
		// Reset: synchroniser then hold while processor reset is up
		st_d.rst_sync = {st_q.rst_sync[RESET_SYNC_STAGES-2:0], supply_ok_in};
		st_d.slot_reset = !st_q.rst_sync[RESET_SYNC_STAGES-1]
			|| (st_q.slot_reset && processor_reset_out);
		// Strap captured once, first clock after supply is good
		if (!st_q.strap_taken && st_q.rst_sync[RESET_SYNC_STAGES-1])
		begin
			st_d.sa1_late    = numeric_error_ignore;
			st_d.strap_taken = 1'b1;
		end
		// Bus clock divider on source edges
		st_d.src_prev = src;
		st_d.sys_rise = 1'b0;
		// Count source rises; odd ratios give a short high phase, not a skewed period
		if (src && !st_q.src_prev)
		begin
			if (st_q.div_cnt + 4'h1 >= ratio)
				div_nx = 4'h0;
			else
				div_nx = st_q.div_cnt + 4'h1;
			st_d.div_cnt  = div_nx;
			st_d.sys_clk  = div_nx < (ratio >> 1);
			// A ratio change mid-period must not fake a rising edge
			st_d.sys_rise = div_nx == 4'h0 && !st_q.sys_clk;
		end
		// Refresh timer and sequencer
		ref_go = 1'b0;
		if (st_q.ref_cnt >= 14'(REFRESH_CYC - 1))
		begin
			st_d.ref_cnt = REFRESH_CNT_INIT;
			ref_go       = 1'b1;
		end
		else
			st_d.ref_cnt = st_q.ref_cnt + 14'h1;
		// An external agent pulling the line low asks for a cycle
		if (!refresh_n_i && !st_q.ref_oe)
			ref_go = 1'b1;
		unique case (st_q.ref_state)
			REF_IDLE:
				if (ref_go && !st_q.cyc_busy)
				begin
					st_d.ref_state = REF_RUN;
					st_d.ref_len   = 3'(REFRESH_LEN_CYC);
					st_d.ref_oe    = 1'b1;
				end
			REF_RUN:
				if (st_q.ref_len == 3'h1)
				begin
					st_d.ref_state = REF_END;
					st_d.ref_oe    = 1'b0;
				end
				else
					st_d.ref_len = st_q.ref_len - 3'h1;
			REF_END:
				st_d.ref_state = REF_IDLE;
			default:
				st_d.ref_state = REF_IDLE;
		endcase
		// Next refresh state, so a bus cycle never starts beside a refresh
		in_ref       = st_d.ref_state != REF_IDLE;
		st_d.ref_act = in_ref;
		// Bus cycle sequencer, stepped on bus clock rising edges
		st_d.done = 1'b0;
		if (st_q.sys_rise)
		begin
			st_d.ale = 1'b0;
			if (!st_q.cyc_busy && bus_req.cyc_valid && !in_ref && !ext_master)
			begin
				st_d.cyc_busy = 1'b1;
				st_d.cyc_mem  = bus_req.is_mem;
				st_d.cyc_wr   = bus_req.is_write;
				st_d.cyc_low  = bus_req.addr < MEG_LIMIT;
				st_d.wait_cnt = default_wait_len;
				st_d.ale      = 1'b1;
			end
			else if (st_q.cyc_busy)
			begin
				if (!ws_term_n && !dma_view.dma_active || st_q.wait_cnt == 4'h0)
				begin
					st_d.cyc_busy = 1'b0;
					st_d.done     = 1'b1;
				end
				else
					st_d.wait_cnt = st_q.wait_cnt - 4'h1;
			end
		end
		st_d.io_rd_n   = !(st_d.cyc_busy && !st_d.cyc_mem && !st_d.cyc_wr && !in_ref);
		st_d.io_wr_n   = !(st_d.cyc_busy && !st_d.cyc_mem && st_d.cyc_wr && !in_ref);
		st_d.smem_rd_n = !(st_d.cyc_busy && st_d.cyc_mem && !st_d.cyc_wr && st_d.cyc_low);
		st_d.smem_wr_n = !(st_d.cyc_busy && st_d.cyc_mem && st_d.cyc_wr && st_d.cyc_low);
		// Low address lines and byte-high enable
		sa = dma_view.dma_active ? dma_view.dma_addr : be_decode(cpu_byte_enables_n);
		st_d.pins.sa_o    = sa;
		st_d.pins.sa_oe   = !ext_master;
		st_d.pins.sbhe_oe = !ext_master;
		if (dma_view.dma_active)
			st_d.pins.sbhe_n_o = dma_view.dma_16bit ? 1'b0 : !sa[0];
		else
			st_d.pins.sbhe_n_o = cpu_byte_enables_n[1] && cpu_byte_enables_n[3];
		st_d.tc = dma_view.tc_any;
	end

	// Clock enable freezes everything, reset takes constants only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= ST_RST;
		else if (clk_en)
			st_q <= st_d;
	end

	// ============================================================
	// Outputs
	assign refresh_n_o     = 1'b0;
	assign refresh_n_oe    = st_q.ref_oe;
	assign slot_reset      = st_q.slot_reset;
	assign addr_pins       = st_q.pins;
	assign sa1_late_timing = st_q.sa1_late;
	assign sys_clk         = st_q.sys_clk;
	assign addr_latch_en   = st_q.ale;
	assign io_rd_n         = st_q.io_rd_n;
	assign io_wr_n         = st_q.io_wr_n;
	assign smem_rd_n       = st_q.smem_rd_n;
	assign smem_wr_n       = st_q.smem_wr_n;
	assign term_count      = st_q.tc;
	assign cycle_done      = st_q.done;
	assign refresh_active  = st_q.ref_act;
endmodule // isa_bus_signal_control
`default_nettype wire

// *** testbench/slot_agent.sv ***
// Slot partner: pulled-up refresh line and a fast peripheral
`default_nettype none
module slot_agent
(
	// Bench controls and strobe activity
	input  wire logic clk,
	input  wire logic ask_refresh,
	input  wire logic fast_ack,
	input  wire logic strobe_on,
	// Slot lines
	input  wire logic dev_pull,
	output logic      refresh_line,
	output logic      ws_term_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic pull_q = 1'b0;
	// ============================================================
	// Open drain: agents only pull low, the pull-up gives the high
	always @(posedge clk)
		pull_q <= ask_refresh;
	assign refresh_line = !(pull_q || dev_pull);
	// Terminates only inside a strobe, as a real card would
	assign ws_term_n = !(fast_ack && strobe_on);
endmodule // slot_agent
`default_nettype wire

// *** testbench/isa_sig_assertions.sv ***
// Checker: port properties of the ISA slot signal block
`default_nettype none
module isa_sig_assertions
	import isa_sig_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Inputs
	input wire logic       processor_reset_out,
	input wire logic       hold_acknowledge,
	input wire logic       master_n,
	input wire bus_req_s   bus_req,
	input wire dma_view_s  dma_view,
	// Outputs
	input wire logic       refresh_n_o,
	input wire logic       refresh_n_oe,
	input wire logic       slot_reset,
	input wire addr_pins_s addr_pins,
	input wire logic       sys_clk,
	input wire logic       addr_latch_en,
	input wire logic       io_rd_n,
	input wire logic       io_wr_n,
	input wire logic       smem_rd_n,
	input wire logic       smem_wr_n,
	input wire logic       term_count,
	input wire logic       refresh_active
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Bound too long for a delay range, so count the gap instead
	logic [10:0] gap_q;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			gap_q <= 11'h000;
		else
			gap_q <= refresh_n_oe ? 11'h000 : gap_q + 11'h001;
	// ============================================================
	// Properties
	refr_low_only_a: assert property
		(refresh_n_o == 1'b0) else $error("refresh line driven high");
	refr_pulse_len_a: assert property
		($rose(refresh_n_oe) |-> refresh_n_oe[*4] ##1 !refresh_n_oe) else $error("refresh length");
	refr_period_a: assert property
		(gap_q < 11'h514) else $error("refresh overdue");
	io_quiet_ref_a: assert property
		(refresh_active |-> io_rd_n && io_wr_n) else $error("io strobe in refresh");
	smem_below_meg_a: assert property
		(($fell(smem_rd_n) || $fell(smem_wr_n)) |-> $past(bus_req.addr) < MEG_LIMIT)
		else $error("memory strobe above 1 MB");
	slot_rst_hold_a: assert property
		(processor_reset_out |=> slot_reset) else $error("slot reset short");
	sa_float_ext_a: assert property
		(hold_acknowledge && !master_n |=> !addr_pins.sa_oe && !addr_pins.sbhe_oe)
		else $error("pins driven under master");
	sa_drive_cpu_a: assert property
		(rst_n && !hold_acknowledge |=> addr_pins.sa_oe && addr_pins.sbhe_oe)
		else $error("pins floating");
	dma_wide_a: assert property
		(hold_acknowledge && master_n && dma_view.dma_active && dma_view.dma_16bit
		|=> !addr_pins.sbhe_n_o && addr_pins.sa_o == $past(dma_view.dma_addr))
		else $error("dma 16 bit pins");
	tc_follow_a: assert property
		($rose(dma_view.tc_any) |=> term_count) else $error("terminal count missing");
	ale_single_a: assert property
		(addr_latch_en && $rose(sys_clk) |=> !addr_latch_en) else $error("latch enable too long");
	ale_on_rise_a: assert property
		($rose(addr_latch_en) |-> $past(sys_clk) && !$past(sys_clk, 2))
		else $error("latch enable off bus clock");
endmodule // isa_sig_assertions
`default_nettype wire

// *** testbench/tb.sv ***
// Testbench: directed scenarios for the ISA slot signal block
`default_nettype none
module tb
	import isa_sig_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ============================================================
	// Signals
	logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, supply_ok_in = 1'b0, osc_select = 1'b1;
	logic processor_reset_out = 1'b1, numeric_error_ignore = 1'b1, fast_ack = 1'b0;
	logic bus_osc_clk = 1'b0, cpu_double_clk = 1'b0, hold_acknowledge = 1'b0, master_n = 1'b1;
	logic [4:0] clock_divide_control = CLKDIV_DIV2;
	logic [3:0] cpu_byte_enables_n = 4'hf, default_wait_len = 4'h3;
	bus_req_s bus_req = '0;
	dma_view_s dma_view = '0;
	logic ask_refresh = 1'b0, refresh_n_i, refresh_n_o, refresh_n_oe, ws_term_n, slot_reset;
	logic sa1_late_timing, sys_clk, addr_latch_en, io_rd_n, io_wr_n, smem_rd_n, smem_wr_n;
	logic term_count, cycle_done, refresh_active;
	addr_pins_s addr_pins;
	int failures = 0, samples_checked = 0, cycles = 0;
	isa_bus_signal_control dut_u
	(
		.clk, .rst_n, .clk_en, .supply_ok_in, .processor_reset_out, .numeric_error_ignore,
		.bus_osc_clk, .cpu_double_clk, .osc_select, .clock_divide_control, .cpu_byte_enables_n,
		.hold_acknowledge, .master_n, .bus_req, .dma_view, .default_wait_len, .refresh_n_i,
		.refresh_n_o, .refresh_n_oe, .ws_term_n, .slot_reset, .addr_pins, .sa1_late_timing,
		.sys_clk, .addr_latch_en, .io_rd_n, .io_wr_n, .smem_rd_n, .smem_wr_n, .term_count,
		.cycle_done, .refresh_active
	);
	slot_agent peer_u
	(
		.clk, .ask_refresh, .fast_ack, .dev_pull(refresh_n_oe), .refresh_line(refresh_n_i),
		.strobe_on(!(io_rd_n && io_wr_n && smem_rd_n && smem_wr_n)), .ws_term_n
	);
	initial
		forever #12.5 clk = ~clk;
	// Source clocks: bus oscillator period 2, cpu clock period 4; hang limit
	always @(posedge clk)
	begin
		bus_osc_clk <= ~bus_osc_clk;
		if (bus_osc_clk)
			cpu_double_clk <= ~cpu_double_clk;
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			$display("MISMATCH %0t timeout", $time);
			complete_run();
		end
	end
	// ============================================================
	// Helpers
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic complete_run();
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_until(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v && n < 700)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic wait_rise(output int n);
		logic p;
		n = 0;
		do
		begin
			p = sys_clk;
			@(posedge clk);
			n++;
		end while (!(p === 1'b0 && sys_clk === 1'b1) && n < 100);
	endtask
	task automatic bus_cycle(input logic mem, wr, fast, input logic [23:0] a, output int len);
		int n;
		logic lo;
		lo = mem && a < MEG_LIMIT;
		bus_req <= '{1'b1, mem, wr, a};
		fast_ack <= fast;
		wait_until(addr_latch_en, 1'b1, n);
		bus_req.cyc_valid <= 1'b0;
		chk({io_rd_n, io_wr_n, smem_rd_n, smem_wr_n} === ~{!mem && !wr, !mem && wr, lo && !wr,
			lo && wr}, "strobe select");
		wait_until(cycle_done, 1'b1, len);
		fast_ack <= 1'b0;
	endtask
	// ============================================================
	// Scenarios
	task automatic t_slot_reset();
		int n;
		supply_ok_in <= 1'b1;
		repeat (8) @(posedge clk);
		chk(slot_reset === 1'b1, "slot reset dropped early");
		processor_reset_out <= 1'b0;
		wait_until(slot_reset, 1'b0, n);
		chk(n >= 2 && n <= 5, "slot reset release");
		chk(sa1_late_timing === 1'b1, "strap not captured");
	endtask
	task automatic t_clock();
		int divs[5] = '{2, 3, 4, 6, 8};
		int n;
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 5; c++)
			begin
				osc_select <= s[0];
				clock_divide_control <= c[4:0];
				wait_rise(n);
				wait_rise(n);
				wait_rise(n);
				chk(n == divs[c] * (s ? 2 : 4), "bus clock period");
			end
		clock_divide_control <= CLKDIV_DIV2;
	endtask
	task automatic t_addr();
		for (int i = 0; i < 4; i++)
		begin
			cpu_byte_enables_n <= ~(4'h1 << i);
			repeat (3) @(posedge clk);
			chk(addr_pins === addr_pins_s'{i[1:0], 1'b1, !(i == 1 || i == 3), 1'b1},
				"byte enable decode");
		end
		hold_acknowledge <= 1'b1;
		master_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk(!addr_pins.sa_oe && !addr_pins.sbhe_oe, "pins driven under master");
		master_n <= 1'b1;
		for (int j = 0; j < 3; j++)
		begin
			dma_view <= '{1'b1, j == 0, j[1:0] + 2'h1, j == 1};
			repeat (3) @(posedge clk);
			chk(addr_pins === addr_pins_s'{j[1:0] + 2'h1, 1'b1, j == 1, 1'b1},
				"dma pins");
			chk(term_count === (j == 1), "terminal count");
		end
		dma_view <= '0;
		hold_acknowledge <= 1'b0;
	endtask
	task automatic t_cycles();
		int l0, l1;
		bus_cycle(1'b1, 1'b0, 1'b0, 24'h0ffffe, l0);
		// Wait length 3 gives four bus clock periods of four clocks
		chk(l0 == 16, "default cycle length");
		bus_cycle(1'b1, 1'b1, 1'b0, 24'h100000, l1);
		bus_cycle(1'b0, 1'b0, 1'b1, 24'h000300, l1);
		chk(l1 < l0, "early terminate ignored");
		bus_cycle(1'b0, 1'b1, 1'b0, 24'h000300, l1);
	endtask
	task automatic t_refresh();
		int n, k;
		wait_until(refresh_n_oe, 1'b1, n);
		wait_until(refresh_n_oe, 1'b0, k);
		chk(k == 4, "refresh pulse length");
		wait_until(refresh_n_oe, 1'b1, n);
		chk(n + k == 624, "refresh interval");
		repeat (60) @(posedge clk);
		ask_refresh <= 1'b1;
		@(posedge clk);
		ask_refresh <= 1'b0;
		wait_until(refresh_n_oe, 1'b1, n);
		chk(n <= 5, "external refresh ignored");
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_slot_reset();
		t_clock();
		t_addr();
		t_cycles();
		t_refresh();
		complete_run();
	end
endmodule // tb
bind isa_bus_signal_control isa_sig_assertions chk_u
(
	.clk, .rst_n, .processor_reset_out, .hold_acknowledge, .master_n, .bus_req, .dma_view,
	.refresh_n_o, .refresh_n_oe, .slot_reset, .addr_pins, .sys_clk, .addr_latch_en, .io_rd_n,
	.io_wr_n, .smem_rd_n, .smem_wr_n, .term_count, .refresh_active
);
`default_nettype wire
